// *** asrc_pkg.sv ***
// Package: pin polarities, timing figures and state encoding for the SRAM host controller
package asrc_pkg;
	// ==========================================================
	// Geometry
	localparam int ADDR_W = 19;
	localparam int DATA_W = 8;
	// ==========================================================
	// Clock and timing figures (ns)
	localparam int CLK_PERIOD_NS       = 50;
	localparam int WRITE_PULSE_NS      = 50;  // Strobe low, slower grade
	localparam int SELECT_TO_END_NS    = 55;  // select_to_write_end_time, slower grade
	localparam int WRITE_TO_FLOAT_NS   = 30;  // write_to_float_delay, slower grade
	localparam int DATA_SETUP_NS       = 30;
	localparam int READ_CYCLE_NS       = 70;
	localparam int ACCESS_NS           = 70;
	localparam int RETENTION_ENTRY_NS  = 0;   // deselect_to_retention_time
	// Least times round up, none below one cycle
	localparam int SEL_CYC   = (SELECT_TO_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC    = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_CYC = (WRITE_TO_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DS_CYC    = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RD_CYC    = ((READ_CYCLE_NS > ACCESS_NS ? READ_CYCLE_NS : ACCESS_NS)
		+ CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RET_CYC   = (RETENTION_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1 :
		(RETENTION_ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W     = 4;
	// ==========================================================
	// Pin levels
	localparam logic PIN_ASSERT_N   = 1'h0;
	localparam logic PIN_DEASSERT_N = 1'h1;
	localparam logic STROBE_READ    = 1'h1;
	localparam logic STROBE_WRITE   = 1'h0;
	// ==========================================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_READ   = 3'b001,
		ST_WSEL   = 3'b010,
		ST_WFLOAT = 3'b011,
		ST_WSTRB  = 3'b100,
		ST_WEND   = 3'b101,
		ST_RET    = 3'b110
	} asrc_state_t;
endpackage : asrc_pkg

// *** asrc_timer_if.sv ***
// Interface: load and expiry of the phase timer
`timescale 1ns/1ps
interface asrc_timer_if;
	import asrc_pkg::*;
	logic             load;
	logic [CNT_W-1:0] value;
	logic             done;
	modport ctrl (output load, output value, input done);
	modport tmr  (input load, input value, output done);
endinterface : asrc_timer_if

// *** asrc_timer.sv ***
// Down counter that times each bus phase except the one-cycle write end
`timescale 1ns/1ps
module asrc_timer
	import asrc_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Control
	asrc_timer_if.tmr t
);
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	// Next count: reload wins, otherwise count toward zero
	always_comb begin
		cnt_d = cnt_q;
		if (t.load) begin
			cnt_d = t.value;
		end else if (cnt_q != '0) begin
			cnt_d = cnt_q - CNT_W'(1);
		end
	end

	// Register
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// Expired when count reaches one or less, so a load of N gives N cycles.
	// Kept free of the load input: the sequencer loads on done, so a term on load would form a loop.
	assign t.done = (cnt_q <= CNT_W'(1));
endmodule : asrc_timer

// *** asrc_host.sv ***
// Host controller for an asynchronous byte-wide SRAM: reads, writes and retention entry
`timescale 1ns/1ps
module asrc_host
	import asrc_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	// Clock and reset
	input  wire logic          REF_CLK,
	input  wire logic          RST,
	// User request port
	input  wire logic          REQ_VALID,
	input  wire logic          REQ_WRITE,
	input  wire logic [AW-1:0] REQ_ADDR,
	input  wire logic [DW-1:0] REQ_WDATA,
	output logic               REQ_READY,
	output logic [DW-1:0]      RSP_RDATA,
	output logic               RSP_VALID,
	// Retention control
	input  wire logic          RET_REQ,
	output logic               RET_ACTIVE,
	// Memory pins
	output logic [AW-1:0]      ADDRESS_PINS,
	output logic               SELECT_N,
	output logic               OUT_EN_N,
	output logic               WRITE_STROBE,
	input  wire logic [DW-1:0] DATA_PINS_I,
	output logic [DW-1:0]      DATA_PINS_O,
	output logic               DATA_PINS_OE
);
	// ==========================================================
	// State
	asrc_state_t     st_q, st_d;
	logic [AW-1:0]   addr_q, addr_d;
	logic [DW-1:0]   wdat_q, wdat_d;
	logic [DW-1:0]   rdat_q, rdat_d;
	logic            rvld_q, rvld_d;
	logic            sel_n_q, sel_n_d;
	logic            oe_n_q, oe_n_d;
	logic            strb_q, strb_d;
	logic            drv_q, drv_d;

	asrc_timer_if tif ();

	asrc_timer u_timer (
		.REF_CLK (REF_CLK),
		.RST     (RST),
		.t       (tif)
	);

	// Timer load helper
	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n < 1 ? 1 : n);
	endfunction : cyc

	// Larger of two cycle counts
	function automatic int max_cyc(input int a, input int b);
		max_cyc = (a > b) ? a : b;
	endfunction : max_cyc

	// Strobe-low phase covering select time, pulse width and data setup at once.
	// One shared phase over-serves the faster grade but keeps a single timer.
	localparam int WR_PHASE_CYC = max_cyc(max_cyc(SEL_CYC, WP_CYC), DS_CYC);

	// ==========================================================
	// Next-state logic
	always_comb begin
		st_d      = st_q;
		addr_d    = addr_q;
		wdat_d    = wdat_q;
		rdat_d    = rdat_q;
		rvld_d    = 1'b0;
		sel_n_d   = sel_n_q;
		oe_n_d    = oe_n_q;
		strb_d    = strb_q;
		drv_d     = drv_q;
		tif.load  = 1'b0;
		tif.value = '0;
		case (st_q)
			ST_IDLE: begin
				// Retention takes priority over new accesses
				if (RET_REQ) begin
					// deselect first
					// Hazard: an access started now would leave select low as the supply falls
					sel_n_d   = PIN_DEASSERT_N;
					oe_n_d    = PIN_DEASSERT_N;
					st_d      = ST_RET;
					tif.load  = 1'b1;
					tif.value = cyc(RET_CYC);
				end else if (REQ_VALID && REQ_WRITE) begin
					addr_d    = REQ_ADDR;
					wdat_d    = REQ_WDATA;
					oe_n_d    = PIN_DEASSERT_N;
					strb_d    = STROBE_WRITE;
					sel_n_d   = PIN_ASSERT_N;
					st_d      = ST_WFLOAT;
					tif.load  = 1'b1;
					tif.value = cyc(FLOAT_CYC);
				end else if (REQ_VALID) begin
					addr_d    = REQ_ADDR;
					strb_d    = STROBE_READ;
					sel_n_d   = PIN_ASSERT_N;
					oe_n_d    = PIN_ASSERT_N;
					st_d      = ST_READ;
					tif.load  = 1'b1;
					tif.value = cyc(RD_CYC);
				end
			end
			ST_READ: begin
				// Data is taken on the last edge of the access window, before select and
				// output enable rise, so the memory's output hold time is not relied on
				if (tif.done) begin
					rdat_d  = DATA_PINS_I;
					rvld_d  = 1'b1;
					sel_n_d = PIN_DEASSERT_N;
					oe_n_d  = PIN_DEASSERT_N;
					st_d    = ST_IDLE;
				end
			end
			ST_WFLOAT: begin
				// wait out the release delay before driving
				if (tif.done) begin
					drv_d     = 1'b1;
					st_d      = ST_WSTRB;
					tif.load  = 1'b1;
					tif.value = cyc(WR_PHASE_CYC);
				end
			end
			ST_WSTRB: begin
				if (tif.done) begin
					// overlap ends here, data still driven
					sel_n_d = PIN_DEASSERT_N;
					strb_d  = STROBE_READ;
					st_d    = ST_WEND;
				end
			end
			ST_WEND: begin
				// stop driving after strobe rise
				// One cycle of drive past the rise gives data hold; no contention, as the
				// memory's outputs stay off with output enable high through the write
				drv_d = 1'b0;
				st_d  = ST_IDLE;
			end
			ST_RET: begin
				// stay deselected while held
				// Limitation: the least stay is one cycle even with no entry time needed
				sel_n_d = PIN_DEASSERT_N;
				if (tif.done && !RET_REQ) begin
					st_d = ST_IDLE;
				end
			end
			default: begin
				st_d    = ST_IDLE;
				sel_n_d = PIN_DEASSERT_N;
				oe_n_d  = PIN_DEASSERT_N;
				strb_d  = STROBE_READ;
				drv_d   = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Registers; pins reset to an idle, deselected bus
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			st_q    <= ST_IDLE;
			addr_q  <= '0;
			wdat_q  <= '0;
			rdat_q  <= '0;
			rvld_q  <= 1'b0;
			sel_n_q <= PIN_DEASSERT_N;
			oe_n_q  <= PIN_DEASSERT_N;
			strb_q  <= STROBE_READ;
			drv_q   <= 1'b0;
		end else begin
			st_q    <= st_d;
			addr_q  <= addr_d;
			wdat_q  <= wdat_d;
			rdat_q  <= rdat_d;
			rvld_q  <= rvld_d;
			sel_n_q <= sel_n_d;
			oe_n_q  <= oe_n_d;
			strb_q  <= strb_d;
			drv_q   <= drv_d;
		end
	end

	// ==========================================================
	// Outputs
	// REQ_READY is combinational so a request is taken on the first edge after the sequencer
	// reaches idle; it drops at once when retention is asked for
	assign REQ_READY    = (st_q == ST_IDLE) && !RET_REQ;
	assign RSP_RDATA    = rdat_q;
	assign RSP_VALID    = rvld_q;
	assign RET_ACTIVE   = (st_q == ST_RET);
	assign ADDRESS_PINS = addr_q;
	assign SELECT_N     = sel_n_q;
	assign OUT_EN_N     = oe_n_q;
	assign WRITE_STROBE = strb_q;
	assign DATA_PINS_O  = wdat_q;
	assign DATA_PINS_OE = drv_q;
endmodule : asrc_host

// *** asrc_host_checker.sv ***
// Concurrent checks on the pins of the SRAM host controller
`timescale 1ns/1ps
module asrc_host_checker
	import asrc_pkg::*;
(
	// Clock and reset
	input wire logic REF_CLK,
	input wire logic RST,
	// Request side
	input wire logic REQ_VALID,
	input wire logic REQ_WRITE,
	input wire logic REQ_READY,
	input wire logic RET_ACTIVE,
	// Memory pins
	input wire logic SELECT_N,
	input wire logic OUT_EN_N,
	input wire logic WRITE_STROBE,
	input wire logic DATA_PINS_OE
);
	// ==========================================================
	// Pin relations, all sampled on the one clock
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	read_strobe_high_a: assert property (!SELECT_N && !OUT_EN_N |-> WRITE_STROBE)
		else $error("Strobe low while memory outputs enabled");
	write_start_a: assert property (REQ_VALID && REQ_READY && REQ_WRITE |=> !SELECT_N && !WRITE_STROBE && OUT_EN_N)
		else $error("Write did not open with select, strobe low and outputs off");
	no_contention_a: assert property ($rose(DATA_PINS_OE) |-> OUT_EN_N && !$past(WRITE_STROBE))
		else $error("Host drove data before memory released it");
	release_end_a: assert property ($rose(WRITE_STROBE) |-> DATA_PINS_OE ##1 !DATA_PINS_OE)
		else $error("Host data not released right after write end");
	select_hold_a: assert property ($fell(SELECT_N) && !WRITE_STROBE |=> !SELECT_N [*2])
		else $error("Select too short before write end");
	retention_desel_a: assert property (RET_ACTIVE |-> SELECT_N && WRITE_STROBE && !DATA_PINS_OE)
		else $error("Memory not deselected in retention");
endmodule : asrc_host_checker

bind asrc_host asrc_host_checker asrc_host_checker_inst (.REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID),
	.REQ_WRITE(REQ_WRITE), .REQ_READY(REQ_READY), .RET_ACTIVE(RET_ACTIVE), .SELECT_N(SELECT_N),
	.OUT_EN_N(OUT_EN_N), .WRITE_STROBE(WRITE_STROBE), .DATA_PINS_OE(DATA_PINS_OE));

// *** asrc_sram_model.sv ***
// Behavioural asynchronous byte-wide memory on the far side of the host
`timescale 1ns/1ps
module asrc_sram_model
	import asrc_pkg::*;
(
	// Memory pins
	input wire logic [ADDR_W-1:0] addr,
	input wire logic              sel_n,
	input wire logic              oe_n,
	input wire logic              wr,
	// Host data drive
	input wire logic [DATA_W-1:0] host_d,
	input wire logic              host_oe,
	// Resolved bus level
	output logic [DATA_W-1:0]     bus
);
	logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
	logic [DATA_W-1:0] last_q = 8'h00;
	logic              drive;
	logic              ovl;
	assign drive = !sel_n && !oe_n && wr;
	// Known from time zero, so the first reset edge is not taken for a write end
	assign ovl   = (sel_n === 1'b0) && (wr === 1'b0);
	// Released bus shows the inverse of its last level, so a stale value never matches
	always @(addr, drive, host_d, host_oe, last_q) begin
		bus = host_oe ? host_d : drive ? (mem.exists(addr) ? mem[addr] : ~addr[7:0]) : ~last_q;
	end
	always @(bus) begin
		if (host_oe || drive) last_q = bus;
	end
	always @(negedge ovl) begin
		mem[addr] = bus;
	end
endmodule : asrc_sram_model

// *** test_async_sram_write_retention_port.sv ***
// Self-checking bench: host controller against a behavioural memory
`timescale 1ns/1ps
module test_async_sram_write_retention_port;
	import asrc_pkg::*;
	// ==========================================================
	// Signals
	logic REF_CLK = 1'h0, RST = 1'h1, REQ_VALID = 1'h0, REQ_WRITE = 1'h0, RET_REQ = 1'h0;
	logic [ADDR_W-1:0] REQ_ADDR = '0, ADDRESS_PINS, a;
	logic [DATA_W-1:0] REQ_WDATA = '0, RSP_RDATA, DATA_PINS_I, DATA_PINS_O, d;
	logic REQ_READY, RSP_VALID, RET_ACTIVE, SELECT_N, OUT_EN_N, WRITE_STROBE, DATA_PINS_OE;
	logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
	int err_count = 0, cmp_count = 0;
	always #25 REF_CLK = ~REF_CLK;
	asrc_host asrc_host_inst (.REF_CLK(REF_CLK), .RST(RST), .REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE),
		.REQ_ADDR(REQ_ADDR), .REQ_WDATA(REQ_WDATA), .REQ_READY(REQ_READY), .RSP_RDATA(RSP_RDATA),
		.RSP_VALID(RSP_VALID), .RET_REQ(RET_REQ), .RET_ACTIVE(RET_ACTIVE), .ADDRESS_PINS(ADDRESS_PINS),
		.SELECT_N(SELECT_N), .OUT_EN_N(OUT_EN_N), .WRITE_STROBE(WRITE_STROBE), .DATA_PINS_I(DATA_PINS_I),
		.DATA_PINS_O(DATA_PINS_O), .DATA_PINS_OE(DATA_PINS_OE));
	asrc_sram_model asrc_sram_model_inst (.addr(ADDRESS_PINS), .sel_n(SELECT_N), .oe_n(OUT_EN_N),
		.wr(WRITE_STROBE), .host_d(DATA_PINS_O), .host_oe(DATA_PINS_OE), .bus(DATA_PINS_I));
	// ==========================================================
	// Comparison, verdict and expectation
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic give_verdict;
		if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	function automatic logic [DATA_W-1:0] expect_rd(input logic [ADDR_W-1:0] ad);
		return ref_mem[ad];
	endfunction : expect_rd
	// One request held until taken; a read then waits for its answer
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] dt);
		int n;
		n = 0;
		// An edge passes first, so REQ_VALID never falls and rises in one time step
		@(posedge REF_CLK);
		#1 REQ_VALID = 1'h1;
		REQ_WRITE = w;
		REQ_ADDR = ad;
		REQ_WDATA = dt;
		do @(posedge REF_CLK); while (REQ_READY !== 1'h1 && ++n < 20);
		check("req_taken", n < 20, 1);
		#1 REQ_VALID = 1'h0;
		check("address_pins", ADDRESS_PINS, ad);
		n = 0;
		if (w) begin
			check("data_pins_o", DATA_PINS_O, dt);
			ref_mem[ad] = dt;
		end else begin
			do begin
				@(posedge REF_CLK);
				#1 n++;
			end while (RSP_VALID !== 1'h1 && n < 20);
			check("read_latency", n, RD_CYC);
			check("read_data", RSP_RDATA, expect_rd(ad));
		end
	endtask : xfer
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(16));
		repeat (10) @(posedge REF_CLK);
		#1 RST = 1'h0;
		// Address ends and back-to-back writes to one place
		xfer(1'h1, '0, 8'h5A);
		xfer(1'h1, '1, 8'hA5);
		xfer(1'h1, '1, 8'h3C);
		xfer(1'h0, '1, 8'h00);
		xfer(1'h0, '0, 8'h00);
		// Random write then read-back pairs
		repeat (30) begin
			a = ADDR_W'($urandom);
			d = DATA_W'($urandom);
			xfer(1'h1, a, d);
			xfer(1'h0, a, 8'h00);
		end
		// Retention: deselected, requests refused, contents kept
		RET_REQ = 1'h1;
		repeat (3) @(posedge REF_CLK);
		#1 check("ret_active", RET_ACTIVE, 1);
		check("select_n", SELECT_N, 1);
		check("req_ready", REQ_READY, 0);
		RET_REQ = 1'h0;
		xfer(1'h0, a, 8'h00);
		give_verdict;
	end
	// Watchdog far beyond the few hundred cycles the sequence needs
	initial begin
		#(CLK_PERIOD_NS * 5000);
		err_count++;
		give_verdict;
	end
endmodule : test_async_sram_write_retention_port
